/* logic/fssac_pkg.sv */
// ==========================================
// Flash status / sleep / abort host package
package fssac_pkg;

   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;

   // ==========================================
   // Command codes
   localparam logic [7:0] CMD_SLEEP = 8'hC0;
   localparam logic [7:0] CMD_ABORT = 8'hE0;

   // ==========================================
   // Status byte layout
   localparam int BIT_READY   = 7;
   localparam int BIT_SUSPEND = 6;
   localparam int BIT_EFAIL   = 5;
   localparam int BIT_PFAIL   = 4;
   localparam int BIT_PROTECT = 3;
   localparam int BIT_SLEEP   = 2;
   localparam logic [7:0] STATUS_KEEP_MASK = 8'hFC;
   localparam logic [7:0] STATUS_RESET     = 8'h00;

   // ==========================================
   // Bus cycle timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int SETUP_NS      = 20;
   localparam int WR_PULSE_NS   = 60;
   localparam int RD_ACCESS_NS  = 200;
   localparam int HOLD_NS       = 20;
   localparam int CNT_W         = 4;
   localparam logic [CNT_W-1:0] SETUP_CYC =
      CNT_W'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WR_PULSE_CYC =
      CNT_W'((WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RD_PULSE_CYC =
      CNT_W'((RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] HOLD_CYC =
      CNT_W'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

   // ==========================================
   // Types
   typedef enum logic [2:0] {
      OP_CLEAR = 3'h0,
      OP_SLEEP = 3'h1,
      OP_ABORT = 3'h2,
      OP_WAKE  = 3'h3,
      OP_POLL  = 3'h4
   } fssac_op_t;

   typedef enum logic [1:0] {
      MODE_ARRAY   = 2'h0,
      MODE_STATUS  = 2'h1,
      MODE_UNKNOWN = 2'h2
   } fssac_mode_t;

   typedef struct packed {
      logic              ceN;
      logic              weN;
      logic              oeN;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic              doutOeN;
   } fssac_pins_t;

   typedef struct packed {
      logic              isWrite;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fssac_req_t;

   localparam fssac_pins_t PINS_IDLE = '{
      ceN: 1'b1, weN: 1'b1, oeN: 1'b1, addr: '0, dout: '0, doutOeN: 1'b1};

   typedef enum logic [3:0] {
      PH_IDLE  = 4'h1,
      PH_SETUP = 4'h2,
      PH_PULSE = 4'h4,
      PH_HOLD  = 4'h8
   } fssac_phase_t;

   typedef enum logic [5:0] {
      S_IDLE  = 6'h01,
      S_UNLK1 = 6'h02,
      S_UNLK2 = 6'h04,
      S_CMD   = 6'h08,
      S_READ  = 6'h10,
      S_DONE  = 6'h20
   } fssac_state_t;

endpackage : fssac_pkg

/* logic/fssac_bus_cycle.sv */
`timescale 1ns/100ps
// ==========================================
// One asynchronous write or read cycle on the flash pins
module fssac_bus_cycle (
   input  wire logic                              ref_clk,
   input  wire logic                              rst,
   input  wire logic                              start,
   input  wire fssac_pkg::fssac_req_t             req,
   input  wire logic [fssac_pkg::DATA_W-1:0]      pinDin,
   output fssac_pkg::fssac_pins_t                 pins,
   output logic [fssac_pkg::DATA_W-1:0]           rdData,
   output logic                                   idle,
   output logic                                   done
);

   typedef struct packed {
      fssac_pkg::fssac_phase_t           phase;
      logic [fssac_pkg::CNT_W-1:0]       cnt;
      logic                              isWrite;
      fssac_pkg::fssac_pins_t            pins;
      logic [fssac_pkg::DATA_W-1:0]      rdData;
      logic                              done;
   } fssac_bus_st_t;

   fssac_bus_st_t st_r;
   fssac_bus_st_t st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.done = 1'b0;
      case (st_r.phase)
         fssac_pkg::PH_IDLE: begin
            if (start) begin
               st_nxt.phase        = fssac_pkg::PH_SETUP;
               st_nxt.cnt          = fssac_pkg::SETUP_CYC;
               st_nxt.isWrite      = req.isWrite;
               st_nxt.pins.ceN     = 1'b0;
               st_nxt.pins.addr    = req.addr;
               st_nxt.pins.dout    = req.data;
               // Data drives only for writes; the flash owns the bus on reads
               st_nxt.pins.doutOeN = ~req.isWrite;
            end
         end
         fssac_pkg::PH_SETUP: begin
            st_nxt.cnt = st_r.cnt - fssac_pkg::CNT_ONE;
            if (st_r.cnt == fssac_pkg::CNT_ONE) begin
               st_nxt.phase = fssac_pkg::PH_PULSE;
               st_nxt.cnt   = st_r.isWrite ? fssac_pkg::WR_PULSE_CYC
                                           : fssac_pkg::RD_PULSE_CYC;
               st_nxt.pins.weN = ~st_r.isWrite;
               st_nxt.pins.oeN = st_r.isWrite;
            end
         end
         fssac_pkg::PH_PULSE: begin
            st_nxt.cnt = st_r.cnt - fssac_pkg::CNT_ONE;
            if (st_r.cnt == fssac_pkg::CNT_ONE) begin
               st_nxt.phase    = fssac_pkg::PH_HOLD;
               st_nxt.cnt      = fssac_pkg::HOLD_CYC;
               // Sample at the end of the access time, before the strobe rises
               st_nxt.rdData   = st_r.isWrite ? st_r.rdData : pinDin;
               st_nxt.pins.weN = 1'b1;
               st_nxt.pins.oeN = 1'b1;
            end
         end
         fssac_pkg::PH_HOLD: begin
            st_nxt.cnt = st_r.cnt - fssac_pkg::CNT_ONE;
            if (st_r.cnt == fssac_pkg::CNT_ONE) begin
               st_nxt.phase = fssac_pkg::PH_IDLE;
               st_nxt.pins  = fssac_pkg::PINS_IDLE;
               st_nxt.done  = 1'b1;
            end
         end
         default: begin
            st_nxt.phase = fssac_pkg::PH_IDLE;
            st_nxt.pins  = fssac_pkg::PINS_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r <= '{phase: fssac_pkg::PH_IDLE, cnt: '0, isWrite: 1'b0,
                   pins: fssac_pkg::PINS_IDLE, rdData: '0, done: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pins   = st_r.pins;
   assign rdData = st_r.rdData;
   assign idle   = (st_r.phase == fssac_pkg::PH_IDLE);
   assign done   = st_r.done;

endmodule : fssac_bus_cycle

/* logic/fssac_ctrl.sv */
`timescale 1ns/100ps
// Functional notes
// - Host clears flags with one clear-status write, then may issue any command.
// - Host writes a read-status, sleep or abort command before any read cycle.
// - Sleep is three write cycles, the last carrying the sleep code.
// - Host masks reserved status bits 1 and 0 when polling.
module fssac_ctrl #(
   parameter logic [fssac_pkg::ADDR_W-1:0] UNLOCK1_ADDR   = 20'h00001,
   parameter logic [7:0]                   UNLOCK1_DATA   = 8'h5A,
   parameter logic [fssac_pkg::ADDR_W-1:0] UNLOCK2_ADDR   = 20'h00002,
   parameter logic [7:0]                   UNLOCK2_DATA   = 8'hA5,
   parameter logic [fssac_pkg::ADDR_W-1:0] CMD_ADDR       = 20'h00001,
   parameter logic [7:0]                   CMD_READ_ARRAY = 8'h01,
   parameter logic [7:0]                   CMD_READ_STAT  = 8'h02,
   parameter logic [7:0]                   CMD_CLEAR_STAT = 8'h03
) (
   input  wire logic                              ref_clk,
   input  wire logic                              rst,
   input  wire logic                              cmdValid,
   input  wire fssac_pkg::fssac_op_t              cmdOp,
   output logic                                   cmdReady,
   output logic                                   cmdDone,
   output logic [7:0]                             statusByte,
   output logic                                   statusValid,
   input  wire logic                              supplyLow,
   input  wire logic [fssac_pkg::DATA_W-1:0]      flashDin,
   output fssac_pkg::fssac_pins_t                 flashPins
);

   typedef struct packed {
      fssac_pkg::fssac_state_t  state;
      fssac_pkg::fssac_op_t     op;
      fssac_pkg::fssac_mode_t   mode;
      logic                     waiting;
      logic                     ready;
      logic                     done;
      logic [7:0]               status;
      logic                     statusValid;
      logic                     lowSeen;
   } fssac_ctrl_st_t;

   fssac_ctrl_st_t        st_r;
   fssac_ctrl_st_t        st_nxt;
   logic                  busStart;
   fssac_pkg::fssac_req_t busReq;
   logic [fssac_pkg::DATA_W-1:0] busRdData;
   logic                  busIdle;
   logic                  busDone;

   function automatic logic [7:0] op_code(input fssac_pkg::fssac_op_t op);
      case (op)
         fssac_pkg::OP_CLEAR: op_code = CMD_CLEAR_STAT;
         fssac_pkg::OP_SLEEP: op_code = fssac_pkg::CMD_SLEEP;
         fssac_pkg::OP_ABORT: op_code = fssac_pkg::CMD_ABORT;
         fssac_pkg::OP_WAKE:  op_code = CMD_READ_ARRAY;
         default:             op_code = CMD_READ_STAT;
      endcase
   endfunction : op_code

   // ==========================================
   // Command sequencer
   always_comb begin
      st_nxt             = st_r;
      st_nxt.done        = 1'b0;
      st_nxt.statusValid = 1'b0;
      busStart           = 1'b0;
      busReq             = '{isWrite: 1'b1, addr: CMD_ADDR, data: '0};
      case (st_r.state)
         fssac_pkg::S_IDLE: begin
            // Flash ignores writes under lockout; afterwards it is in read-array mode
            if (supplyLow) begin
               st_nxt.lowSeen = 1'b1;
               st_nxt.ready   = 1'b0;
            end else if (st_r.lowSeen) begin
               st_nxt.lowSeen = 1'b0;
               st_nxt.mode    = fssac_pkg::MODE_ARRAY;
               st_nxt.ready   = 1'b1;
            end else if (cmdValid && st_r.ready) begin
               st_nxt.op    = cmdOp;
               st_nxt.ready = 1'b0;
               if (cmdOp == fssac_pkg::OP_SLEEP || cmdOp == fssac_pkg::OP_ABORT) begin
                  st_nxt.state = fssac_pkg::S_UNLK1;
               end else if (cmdOp == fssac_pkg::OP_POLL &&
                            st_r.mode == fssac_pkg::MODE_STATUS) begin
                  st_nxt.state = fssac_pkg::S_READ;
               end else begin
                  st_nxt.state = fssac_pkg::S_CMD;
               end
            end
         end
         fssac_pkg::S_UNLK1,
         fssac_pkg::S_UNLK2,
         fssac_pkg::S_CMD,
         fssac_pkg::S_READ: begin
            case (st_r.state)
               fssac_pkg::S_UNLK1: busReq = '{1'b1, UNLOCK1_ADDR, {8'h00, UNLOCK1_DATA}};
               fssac_pkg::S_UNLK2: busReq = '{1'b1, UNLOCK2_ADDR, {8'h00, UNLOCK2_DATA}};
               fssac_pkg::S_READ:  busReq = '{1'b0, CMD_ADDR, '0};
               default:            busReq = '{1'b1, CMD_ADDR, {8'h00, op_code(st_r.op)}};
            endcase
            if (!st_r.waiting && busIdle) begin
               busStart       = 1'b1;
               st_nxt.waiting = 1'b1;
            end else if (st_r.waiting && busDone) begin
               st_nxt.waiting = 1'b0;
               case (st_r.state)
                  fssac_pkg::S_UNLK1: st_nxt.state = fssac_pkg::S_UNLK2;
                  fssac_pkg::S_UNLK2: st_nxt.state = fssac_pkg::S_CMD;
                  fssac_pkg::S_READ: begin
                     // Reserved low bits are undefined and never reach the user
                     st_nxt.status      = busRdData[7:0] & fssac_pkg::STATUS_KEEP_MASK;
                     st_nxt.statusValid = 1'b1;
                     st_nxt.state       = fssac_pkg::S_DONE;
                  end
                  default: begin
                     // Sleep and abort leave the flash in status-read mode
                     if (st_r.op == fssac_pkg::OP_WAKE) begin
                        st_nxt.mode = fssac_pkg::MODE_ARRAY;
                     end else if (st_r.op != fssac_pkg::OP_CLEAR) begin
                        st_nxt.mode = fssac_pkg::MODE_STATUS;
                     end
                     st_nxt.state = (st_r.op == fssac_pkg::OP_POLL) ? fssac_pkg::S_READ
                                                                     : fssac_pkg::S_DONE;
                  end
               endcase
            end
         end
         fssac_pkg::S_DONE: begin
            st_nxt.done  = 1'b1;
            st_nxt.ready = 1'b1;
            st_nxt.state = fssac_pkg::S_IDLE;
         end
         default: begin
            st_nxt.state = fssac_pkg::S_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r <= '{state: fssac_pkg::S_IDLE, op: fssac_pkg::OP_POLL,
                   mode: fssac_pkg::MODE_ARRAY, waiting: 1'b0, ready: 1'b1,
                   done: 1'b0, status: fssac_pkg::STATUS_RESET, statusValid: 1'b0,
                   lowSeen: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   fssac_bus_cycle u_bus (
      .ref_clk (ref_clk),
      .rst     (rst),
      .start   (busStart),
      .req     (busReq),
      .pinDin  (flashDin),
      .pins    (flashPins),
      .rdData  (busRdData),
      .idle    (busIdle),
      .done    (busDone)
   );

   assign cmdReady    = st_r.ready;
   assign cmdDone     = st_r.done;
   assign statusByte  = st_r.status;
   assign statusValid = st_r.statusValid;

   // ==========================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   logic [1:0] unlockCnt;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         unlockCnt <= 2'h0;
      end else if (busStart && st_r.state == fssac_pkg::S_UNLK1) begin
         unlockCnt <= 2'h1;
      end else if (busStart && st_r.state == fssac_pkg::S_UNLK2) begin
         unlockCnt <= (unlockCnt == 2'h1) ? 2'h2 : 2'h0;
      end else if (busStart) begin
         unlockCnt <= 2'h0;
      end
   end

   sequence clearCmdIssued;
      busStart && st_r.state == fssac_pkg::S_CMD && st_r.op == fssac_pkg::OP_CLEAR;
   endsequence
   sequence readyAgain;
      ##[1:40] cmdReady;
   endsequence

   pollMask_a: assert property (statusValid |-> statusByte[1:0] == 2'h0)
      else $error("reserved status bits reached the user");
   readAfterMode_a: assert property (
      (busStart && !busReq.isWrite) |-> st_r.mode == fssac_pkg::MODE_STATUS)
      else $error("read cycle without status read command");
   sleepUnlock_a: assert property (
      (busStart && busReq.isWrite && busReq.data[7:0] == fssac_pkg::CMD_SLEEP
       && st_r.state == fssac_pkg::S_CMD) |-> unlockCnt == 2'h2)
      else $error("sleep code not preceded by two unlock writes");
   clearThenReady_a: assert property (clearCmdIssued |-> readyAgain)
      else $error("controller not ready after clear status");
   doneOneCycle_a: assert property (cmdDone |=> !cmdDone)
      else $error("command done longer than one cycle");
   lockoutHold_a: assert property (
      (supplyLow && st_r.state == fssac_pkg::S_IDLE) |=> !cmdReady && !busStart)
      else $error("command accepted under supply lockout");

endmodule : fssac_ctrl

/* sim/fssac_flash_model.sv */
`timescale 1ns/100ps
// ==========================================
// Behavioural flash device behind the pins
module fssac_flash_model #(
   parameter logic [7:0] OP_CYC   = 8'h78,
   parameter logic [7:0] SUSP_CYC = 8'h40
) (
   input  wire logic                         ref_clk,
   input  wire logic                         rst,
   input  wire fssac_pkg::fssac_pins_t       pins,
   input  wire logic                         supplyLow,
   input  wire logic                         opStart,
   input  wire logic                         opErase,
   input  wire logic                         opRetryOver,
   input  wire logic                         suspendReq,
   output logic [fssac_pkg::DATA_W-1:0]      dq,
   output logic [7:0]                        status
);
   logic [7:0]  status_r;
   logic        arrayMode_r;
   logic [1:0]  step_r;
   logic        weDly_r;
   logic        erase_r;
   logic        sleepPend_r;
   logic        suspended_r;
   logic        failPend_r;
   logic [7:0]  busyCnt_r;
   logic [15:0] lastDq_r;
   logic        wrEdge;
   logic        rdOn;
   logic [7:0]  wd;

   assign status = status_r;
   assign wrEdge = !weDly_r && pins.weN && !pins.ceN;
   assign rdOn   = !pins.ceN && !pins.oeN;
   assign wd     = pins.dout[7:0];
   // Reserved bits and upper byte left dirty: host must mask them
   assign dq = rdOn ? (arrayMode_r ? 16'hA55A : {8'h3C, status_r[7:2], 2'b11})
             : (!pins.doutOeN ? pins.dout : ~lastDq_r);

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         status_r    <= 8'h80;
         arrayMode_r <= 1'b1;
         step_r      <= 2'h0;
         weDly_r     <= 1'b1;
         erase_r     <= 1'b0;
         sleepPend_r <= 1'b0;
         suspended_r <= 1'b0;
         failPend_r  <= 1'b0;
         busyCnt_r   <= 8'h00;
         lastDq_r    <= 16'h0000;
      end else begin
         weDly_r  <= pins.weN;
         lastDq_r <= dq;
         if (busyCnt_r == 8'h01) begin
            status_r[7] <= 1'b1;
            if (sleepPend_r) status_r[2] <= 1'b1;
            // Retry overflow reported only when the operation ends
            if (failPend_r && erase_r) status_r[5] <= 1'b1;
            if (failPend_r && !erase_r) status_r[4] <= 1'b1;
            sleepPend_r <= 1'b0;
            failPend_r  <= 1'b0;
         end
         if (busyCnt_r != 8'h00) busyCnt_r <= busyCnt_r - 8'h01;
         if (opStart && busyCnt_r == 8'h00 && status_r[5:4] == 2'b00) begin
            busyCnt_r   <= OP_CYC;
            erase_r     <= opErase;
            failPend_r  <= opRetryOver;
            status_r[7] <= 1'b0;
            arrayMode_r <= 1'b0;
         end
         // Suspend stays busy for a while, then reports ready with bit 6 kept
         if (suspendReq && erase_r && busyCnt_r > 8'h01) begin
            busyCnt_r   <= SUSP_CYC;
            status_r[6] <= 1'b1;
            suspended_r <= 1'b1;
         end
         if (supplyLow) begin
            arrayMode_r <= 1'b1;
            step_r      <= 2'h0;
            busyCnt_r   <= 8'h00;
            status_r[7] <= 1'b1;
            status_r[6] <= 1'b0;
            suspended_r <= 1'b0;
         end else if (wrEdge) begin
            step_r <= 2'h0;
            if (step_r == 2'h0 && pins.addr == 20'h00001 && wd == 8'h5A) step_r <= 2'h1;
            else if (step_r == 2'h1 && pins.addr == 20'h00002 && wd == 8'hA5) step_r <= 2'h2;
            else if (step_r == 2'h2 && wd == fssac_pkg::CMD_SLEEP
                     && !suspended_r) begin
               arrayMode_r <= 1'b0;
               if (busyCnt_r > 8'h01) sleepPend_r <= 1'b1;
               else status_r[2] <= 1'b1;
            end else if (step_r == 2'h2 && wd == fssac_pkg::CMD_ABORT && busyCnt_r > 8'h01) begin
               busyCnt_r   <= 8'h00;
               status_r[7] <= 1'b1;
               status_r[2] <= 1'b1;
               arrayMode_r <= 1'b0;
               if (erase_r) status_r[5] <= 1'b1;
               else status_r[4] <= 1'b1;
            end else if (step_r == 2'h0 && wd == 8'h01) begin
               arrayMode_r <= 1'b1;
               status_r[2] <= 1'b0;
            end else if (step_r == 2'h0 && wd == 8'h02) arrayMode_r <= 1'b0;
            else if (step_r == 2'h0 && wd == 8'h03) status_r[5:4] <= 2'b00;
         end
      end
   end
endmodule : fssac_flash_model

/* sim/tb_top.sv */
`timescale 1ns/100ps
// ==========================================
// Self-checking bench for the host controller
module tb_top;
   logic                         ref_clk;
   logic                         rst;
   logic                         cmdValid;
   fssac_pkg::fssac_op_t         cmdOp;
   logic                         cmdReady;
   logic                         cmdDone;
   logic [7:0]                   statusByte;
   logic                         statusValid;
   logic                         supplyLow;
   logic                         opStart;
   logic                         opErase;
   logic                         opRetryOver;
   logic                         suspendReq;
   logic                         sawValid;
   logic [fssac_pkg::DATA_W-1:0] flashDin;
   fssac_pkg::fssac_pins_t       flashPins;
   int                           n_fail;
   int                           tests_run;
   fssac_pkg::fssac_op_t         rowOp [10];
   logic [7:0]                   rowExp [10];

   fssac_ctrl dut (.ref_clk(ref_clk), .rst(rst), .cmdValid(cmdValid), .cmdOp(cmdOp),
      .cmdReady(cmdReady), .cmdDone(cmdDone), .statusByte(statusByte),
      .statusValid(statusValid), .supplyLow(supplyLow), .flashDin(flashDin),
      .flashPins(flashPins));
   fssac_flash_model flash (.ref_clk(ref_clk), .rst(rst), .pins(flashPins),
      .supplyLow(supplyLow), .opStart(opStart), .opErase(opErase), .opRetryOver(opRetryOver),
      .suspendReq(suspendReq), .dq(flashDin), .status());

   always #10 ref_clk = ~ref_clk;

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim;
      $display("counts: compares=%0d mismatches=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim

   task automatic waitCyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : waitCyc

   // Request only when cmdReady is known high; no queue behind it
   task automatic doCmd(input fssac_pkg::fssac_op_t op);
      int i;
      cmdValid = 1'b1;
      cmdOp = op;
      waitCyc(1);
      cmdValid = 1'b0;
      // Status pulse comes one cycle before done, so it is caught on the way
      sawValid = 1'b0;
      for (i = 0; i < 300 && cmdDone !== 1'b1; i++) begin
         waitCyc(1);
         if (statusValid === 1'b1) sawValid = 1'b1;
      end
      if (cmdDone !== 1'b1) begin
         n_fail++;
         end_sim();
      end
   endtask : doCmd

   task automatic startOp(input logic erase);
      opStart = 1'b1;
      opErase = erase;
      waitCyc(1);
      opStart = 1'b0;
   endtask : startOp

   initial begin
      int i;
      ref_clk = 1'b0;
      rst = 1'b1;
      cmdValid = 1'b0;
      cmdOp = fssac_pkg::OP_POLL;
      supplyLow = 1'b0;
      opStart = 1'b0;
      opErase = 1'b0;
      opRetryOver = 1'b0;
      suspendReq = 1'b0;
      sawValid = 1'b0;
      n_fail = 0;
      tests_run = 0;
      rowOp = '{fssac_pkg::OP_POLL, fssac_pkg::OP_SLEEP, fssac_pkg::OP_POLL,
         fssac_pkg::OP_POLL, fssac_pkg::OP_WAKE, fssac_pkg::OP_POLL, fssac_pkg::OP_ABORT,
         fssac_pkg::OP_POLL, fssac_pkg::OP_CLEAR, fssac_pkg::OP_POLL};
      rowExp = '{8'h80, 8'h00, 8'h84, 8'h84, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h80};
      repeat (2) @(posedge ref_clk);
      #1 rst = 1'b0;
      chk(statusByte, 8'h00);
      chk(cmdReady, 1'b1);
      chk(flashPins, fssac_pkg::PINS_IDLE);
      $display("test reset done");
      for (int r = 0; r < 10; r++) begin
         doCmd(rowOp[r]);
         chk(sawValid, rowOp[r] == fssac_pkg::OP_POLL);
         if (rowOp[r] == fssac_pkg::OP_POLL) chk(statusByte, rowExp[r]);
      end
      $display("test rows done");
      startOp(1'b0);
      doCmd(fssac_pkg::OP_ABORT);
      doCmd(fssac_pkg::OP_POLL);
      chk(statusByte, 8'h94);
      doCmd(fssac_pkg::OP_CLEAR);
      doCmd(fssac_pkg::OP_POLL);
      chk(statusByte, 8'h84);
      doCmd(fssac_pkg::OP_WAKE);
      $display("test program abort done");
      startOp(1'b1);
      doCmd(fssac_pkg::OP_SLEEP);
      doCmd(fssac_pkg::OP_POLL);
      chk(statusByte, 8'h00);
      waitCyc(150);
      doCmd(fssac_pkg::OP_POLL);
      chk(statusByte, 8'h84);
      doCmd(fssac_pkg::OP_WAKE);
      $display("test sleep while busy done");
      startOp(1'b1);
      doCmd(fssac_pkg::OP_ABORT);
      startOp(1'b0);
      doCmd(fssac_pkg::OP_POLL);
      chk(statusByte, 8'hA4);
      doCmd(fssac_pkg::OP_CLEAR);
      doCmd(fssac_pkg::OP_WAKE);
      doCmd(fssac_pkg::OP_POLL);
      chk(statusByte, 8'h80);
      $display("test erase abort done");
      opRetryOver = 1'b1;
      startOp(1'b1);
      opRetryOver = 1'b0;
      waitCyc(130);
      doCmd(fssac_pkg::OP_POLL);
      chk(statusByte, 8'hA0);
      doCmd(fssac_pkg::OP_CLEAR);
      $display("test retry overflow done");
      startOp(1'b1);
      suspendReq = 1'b1;
      waitCyc(1);
      suspendReq = 1'b0;
      doCmd(fssac_pkg::OP_POLL);
      chk(statusByte, 8'h40);
      doCmd(fssac_pkg::OP_SLEEP);
      waitCyc(70);
      doCmd(fssac_pkg::OP_POLL);
      chk(statusByte, 8'hC0);
      $display("test erase suspend done");
      startOp(1'b1);
      supplyLow = 1'b1;
      waitCyc(3);
      chk(cmdReady, 1'b0);
      supplyLow = 1'b0;
      for (i = 0; i < 20 && cmdReady !== 1'b1; i++) waitCyc(1);
      chk(cmdReady, 1'b1);
      if (cmdReady !== 1'b1) end_sim();
      doCmd(fssac_pkg::OP_POLL);
      chk(statusByte, 8'h80);
      $display("test supply lockout done");
      end_sim();
   end
endmodule : tb_top
